// ==== logic/dtc_defines.vh ====
// Constants for the diskette track controller.
// Summary of operation
// - 77 tracks, 26 sectors of 128 bytes
// - Data moves by DMA; interrupt on service
// - Operation starts when task word arrives
// - Idle spindle accepts; execution may wait
// - Busy spindle refuses all but control word
// - Sector field advances after good data field
// - Extended transfers follow ascending sector numbers; the code extends read tasks only, a write task ends after one sector
// - Read error stops without sector advance
// - Mark before, two check bytes after fields
// - Third identifier byte is compared sector number
// - Format writes 26 sectors, zero data; the code stops sooner once the range count reaches zero
// - Deleted mark written; reads skip such fields
// - First gap 40 bytes, 47 without mark
// - Index mark field: six zeros, mark
// - Second gap 26 bytes
// - Identifier: six zeros, identifier mark
// - First identifier byte is track number
// - Any sector number, any order
// - Identifier check preset ones, mark through byte four
// - Third gap 11 bytes
// - Data block: six zeros, data mark
// - Data field 128 bytes, zero padded
// - Fourth gap 27 bytes
`ifndef DTC_DEFINES_VH
`define DTC_DEFINES_VH
`define DTC_REG_ADDR 4'h0
`define DTC_REG_RANGE 4'h1
`define DTC_REG_CFGA 4'h2
`define DTC_REG_CFGB 4'h3
`define DTC_REG_TASK 4'h4
`define DTC_REG_CTRL 4'h5
`define DTC_REG_STAT 4'h6
`define DTC_REG_GAPFILL 4'h7
`define DTC_TASK_READ 3'h1
`define DTC_TASK_WRITE 3'h2
`define DTC_TASK_WRDEL 3'h3
`define DTC_TASK_FORMAT 3'h4
`define DTC_LAST_TRACK 8'h4c
`define DTC_SECTORS 8'h1a
`define DTC_DATA_LEN 8'h80
`define DTC_GAP1 8'h28
`define DTC_GAP1_LONG 8'h2f
`define DTC_GAP2 8'h1a
`define DTC_GAP3 8'h0b
`define DTC_GAP4 8'h1b
`define DTC_SYNC 8'h06
`define DTC_ID_LEN 8'h04
`define DTC_CRC_POLY 16'h1021
`define DTC_CRC_INIT 16'hffff
`define DTC_INDEX_MARK 8'hfc
`define DTC_ID_MARK 8'hfe
`define DTC_DATA_MARK 8'hfb
`define DTC_DEL_MARK 8'hf8
`endif

// ==== logic/dtc_track_controller.v ====
// Track controller: register port, DMA byte stream, track framing.
`timescale 1ns/1ns
`include "dtc_defines.vh"
module dtc_track_controller (
  input wire clk,
  input wire rst,
  input wire [3:0] regAddr,
  input wire [15:0] regWrData,
  input wire regWr,
  input wire regRd,
  output reg [15:0] regRdData,
  output reg regNak,
  output wire dmaReq,
  output reg [15:0] dmaAddr,
  input wire dmaAck,
  input wire [7:0] dmaRdData,
  output reg [7:0] dmaWrData,
  output reg dmaWrite,
  output reg irq,
  input wire indexPulse,
  input wire [7:0] rdByte,
  input wire rdByteValid,
  input wire rdMarkFlag,
  input wire otherXfer,
  output reg [7:0] wrByte,
  output reg wrMark,
  output reg wrByteValid,
  output reg wrGate,
  input wire byteTick
);

  // ****************************************************************
  // State encoding
  // ****************************************************************
  localparam [11:0] ST_IDLE = 12'h001;
  localparam [11:0] ST_GAP = 12'h002;
  localparam [11:0] ST_SYNC = 12'h004;
  localparam [11:0] ST_MARK = 12'h008;
  localparam [11:0] ST_ID = 12'h010;
  localparam [11:0] ST_CRC = 12'h020;
  localparam [11:0] ST_DATA = 12'h040;
  localparam [11:0] ST_SRCH = 12'h080;
  localparam [11:0] ST_RDATA = 12'h100;
  localparam [11:0] ST_RCRC = 12'h200;
  localparam [11:0] ST_WAIT = 12'h400;
  localparam [11:0] ST_DONE = 12'h800;

  localparam [2:0] FLD_GAP1 = 3'h0;
  localparam [2:0] FLD_IDXM = 3'h1;
  localparam [2:0] FLD_GAP2 = 3'h2;
  localparam [2:0] FLD_IDM = 3'h3;
  localparam [2:0] FLD_GAP3 = 3'h4;
  localparam [2:0] FLD_DATM = 3'h5;
  localparam [2:0] FLD_GAP4 = 3'h6;

  function [15:0] crcStep;
    input [15:0] crc;
    input [7:0] data;
    integer i;
    reg [15:0] c;
    begin
      c = crc;
      for (i = 7; i >= 0; i = i - 1) begin
        if (c[15] ^ data[i]) begin
          c = {c[14:0], 1'b0} ^ `DTC_CRC_POLY;
        end else begin
          c = {c[14:0], 1'b0};
        end
      end
      crcStep = c;
    end
  endfunction

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  reg [1:0] idxSync_q;
  reg [1:0] tickSync_q;
  reg idxPrev_q;
  reg tickPrev_q;
  wire indexEdge = idxSync_q[1] & ~idxPrev_q;
  wire tick = tickSync_q[1] & ~tickPrev_q;

  always @(posedge clk) begin
    if (rst) begin
      idxSync_q <= 2'h0;
      tickSync_q <= 2'h0;
      idxPrev_q <= 1'b0;
      tickPrev_q <= 1'b0;
    end else begin
      idxSync_q <= {idxSync_q[0], indexPulse};
      tickSync_q <= {tickSync_q[0], byteTick};
      idxPrev_q <= idxSync_q[1];
      tickPrev_q <= tickSync_q[1];
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  reg [15:0] addr_q;
  reg [15:0] range_q;
  reg [15:0] cfgA_q;
  reg [15:0] cfgB_q;
  reg [2:0] task_q;
  reg [2:0] extCount_q;
  reg idxMarkEn_q;
  reg gapFill_q;
  reg intEn_q;
  reg busy_q;
  reg readErr_q;
  reg rangeEnd_q;
  reg [11:0] state_q;
  reg [2:0] field_q;
  reg [7:0] count_q;
  reg [7:0] secCount_q;
  reg [15:0] crc_q;
  reg [7:0] idBuf_q [0:3];
  reg idMatch_q;
  reg delMark_q;
  reg dmaPend_q;
  reg [7:0] dmaByte_q;
  reg dmaHave_q;

  wire isRead = (task_q == `DTC_TASK_READ);
  wire isFormat = (task_q == `DTC_TASK_FORMAT);
  wire refused = busy_q && (regAddr != `DTC_REG_CTRL) && (regWr || regRd);

  assign dmaReq = dmaPend_q;

  always @(posedge clk) begin
    if (rst) begin
      regRdData <= 16'h0000;
      regNak <= 1'b0;
    end else begin
      regNak <= refused;
      regRdData <= 16'h0000;
      if (regRd && !refused) begin
        case (regAddr)
          `DTC_REG_ADDR: regRdData <= addr_q;
          `DTC_REG_RANGE: regRdData <= range_q;
          `DTC_REG_CFGA: regRdData <= cfgA_q;
          `DTC_REG_CFGB: regRdData <= cfgB_q;
          `DTC_REG_TASK: regRdData <= {13'h0000, task_q};
          `DTC_REG_CTRL: regRdData <= {12'h000, extCount_q[1:0], idxMarkEn_q, intEn_q};
          `DTC_REG_STAT: regRdData <= {13'h0000, rangeEnd_q, readErr_q, busy_q};
          `DTC_REG_GAPFILL: regRdData <= {15'h0000, gapFill_q};
          default: regRdData <= 16'h0000;
        endcase
      end
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  // Byte emitted for the current state, and whether it goes out as a mark.
  reg [7:0] outByte;
  reg outMark;
  always @* begin
    outByte = gapFill_q ? 8'hff : 8'h00;
    outMark = 1'b0;
    case (state_q)
      ST_SYNC: outByte = 8'h00;
      ST_MARK: begin
        outMark = 1'b1;
        case (field_q)
          FLD_IDXM: outByte = `DTC_INDEX_MARK;
          FLD_IDM: outByte = `DTC_ID_MARK;
          default: outByte = delMark_q ? `DTC_DEL_MARK : `DTC_DATA_MARK;
        endcase
      end
      ST_ID: outByte = dmaByte_q;
      ST_CRC: outByte = (count_q == 8'h00) ? crc_q[15:8] : crc_q[7:0];
      ST_DATA: outByte = (isFormat || range_q == 16'h0000) ? 8'h00 : dmaByte_q;
      default: outByte = gapFill_q ? 8'hff : 8'h00;
    endcase
  end

  wire emitting = state_q[1] | state_q[2] | state_q[3] | state_q[4] | state_q[5] | state_q[6];
  wire needDma = (state_q == ST_ID) || (state_q == ST_DATA && !isFormat && range_q != 16'h0000);
  wire stall = needDma && !dmaHave_q;

  always @(posedge clk) begin
    if (rst) begin
      addr_q <= 16'h0000;
      range_q <= 16'h0000;
      cfgA_q <= 16'h0000;
      cfgB_q <= 16'h0000;
      task_q <= 3'h0;
      extCount_q <= 3'h0;
      idxMarkEn_q <= 1'b1;
      gapFill_q <= 1'b0;
      intEn_q <= 1'b0;
      busy_q <= 1'b0;
      readErr_q <= 1'b0;
      rangeEnd_q <= 1'b0;
      state_q <= ST_IDLE;
      field_q <= FLD_GAP1;
      count_q <= 8'h00;
      secCount_q <= 8'h00;
      crc_q <= `DTC_CRC_INIT;
      idMatch_q <= 1'b0;
      delMark_q <= 1'b0;
      dmaPend_q <= 1'b0;
      dmaByte_q <= 8'h00;
      dmaHave_q <= 1'b0;
      dmaAddr <= 16'h0000;
      dmaWrData <= 8'h00;
      dmaWrite <= 1'b0;
      irq <= 1'b0;
      wrByte <= 8'h00;
      wrMark <= 1'b0;
      wrByteValid <= 1'b0;
      wrGate <= 1'b0;
    end else begin
      irq <= 1'b0;
      wrByteValid <= 1'b0;
      if (regWr && !refused) begin
        case (regAddr)
          `DTC_REG_ADDR: addr_q <= regWrData;
          `DTC_REG_RANGE: range_q <= regWrData;
          `DTC_REG_CFGA: cfgA_q <= regWrData;
          `DTC_REG_CFGB: cfgB_q <= regWrData;
          `DTC_REG_CTRL: begin
            intEn_q <= regWrData[0];
            idxMarkEn_q <= regWrData[1];
            extCount_q <= {1'b0, regWrData[3:2]};
          end
          `DTC_REG_GAPFILL: gapFill_q <= regWrData[0];
          `DTC_REG_TASK: begin
            if (regWrData[2:0] != 3'h0) begin
              task_q <= regWrData[2:0];
              busy_q <= 1'b1;
              readErr_q <= 1'b0;
              rangeEnd_q <= 1'b0;
              delMark_q <= (regWrData[2:0] == `DTC_TASK_WRDEL);
              secCount_q <= 8'h00;
              state_q <= ST_WAIT;
            end
          end
          default: begin
          end
        endcase
      end
      // DMA fetch or store, one byte per grant.
      if (dmaPend_q && dmaAck) begin
        dmaPend_q <= 1'b0;
        dmaAddr <= dmaAddr + 16'h0001;
        if (!dmaWrite) begin
          dmaByte_q <= dmaRdData;
          dmaHave_q <= 1'b1;
        end
      end
      if (!dmaPend_q && needDma && !dmaHave_q) begin
        dmaPend_q <= 1'b1;
        dmaWrite <= 1'b0;
      end
      case (state_q)
        ST_WAIT: begin
          if (!otherXfer && indexEdge) begin
            dmaAddr <= addr_q;
            if (isFormat) begin
              state_q <= ST_GAP;
              field_q <= FLD_GAP1;
              count_q <= idxMarkEn_q ? `DTC_GAP1 : `DTC_GAP1_LONG;
              wrGate <= 1'b1;
            end else begin
              state_q <= ST_SRCH;
              count_q <= 8'h00;
              idMatch_q <= 1'b0;
            end
          end
        end
        ST_SRCH: begin
          if (rdByteValid) begin
            if (rdMarkFlag && rdByte == `DTC_ID_MARK) begin
              count_q <= 8'h01;
              crc_q <= crcStep(`DTC_CRC_INIT, rdByte);
            end else if (rdMarkFlag && count_q == 8'h07) begin
              // Data mark after an identifier that matched.
              if (idMatch_q && rdByte == `DTC_DEL_MARK && isRead) begin
                idMatch_q <= 1'b0;
              end else if (idMatch_q && isRead) begin
                state_q <= ST_RDATA;
                count_q <= 8'h00;
                crc_q <= crcStep(`DTC_CRC_INIT, rdByte);
              end
            end else if (count_q >= 8'h01 && count_q <= 8'h04) begin
              idBuf_q[count_q[1:0] - 2'h1] <= rdByte;
              crc_q <= crcStep(crc_q, rdByte);
              count_q <= count_q + 8'h01;
            end else if (count_q == 8'h05 || count_q == 8'h06) begin
              crc_q <= crcStep(crc_q, rdByte);
              count_q <= count_q + 8'h01;
              if (count_q == 8'h06) begin
                // Match track and sector; reserved bytes ignored.
                idMatch_q <= (crcStep(crc_q, rdByte) == 16'h0000) &&
                  (idBuf_q[0] == cfgA_q[7:0]) && (idBuf_q[2] == cfgB_q[7:0]);
                if (!isRead && idBuf_q[0] == cfgA_q[7:0] && idBuf_q[2] == cfgB_q[7:0]) begin
                  state_q <= ST_GAP;
                  field_q <= FLD_GAP3;
                  count_q <= `DTC_GAP3;
                  wrGate <= 1'b1;
                end
              end
            end
          end
        end
        ST_RDATA: begin
          if (rdByteValid) begin
            crc_q <= crcStep(crc_q, rdByte);
            count_q <= count_q + 8'h01;
            if (count_q < `DTC_DATA_LEN && range_q != 16'h0000) begin
              dmaWrData <= rdByte;
              dmaWrite <= 1'b1;
              dmaPend_q <= 1'b1;
              range_q <= range_q - 16'h0001;
            end
            if (count_q == `DTC_DATA_LEN + 8'h01) begin
              if (crcStep(crc_q, rdByte) != 16'h0000) begin
                readErr_q <= 1'b1;
                state_q <= ST_DONE;
              end else begin
                cfgB_q[7:0] <= cfgB_q[7:0] + 8'h01;
                state_q <= (extCount_q != 3'h0 && range_q != 16'h0000) ? ST_SRCH : ST_DONE;
                extCount_q <= (extCount_q != 3'h0) ? extCount_q - 3'h1 : 3'h0;
                count_q <= 8'h00;
                idMatch_q <= 1'b0;
              end
            end
          end
        end
        ST_DONE: begin
          busy_q <= 1'b0;
          wrGate <= 1'b0;
          rangeEnd_q <= (range_q == 16'h0000);
          irq <= intEn_q;
          state_q <= ST_IDLE;
        end
        default: begin
        end
      endcase
      // Byte-time driven writing of the framed track.
      if (emitting && tick && !stall) begin
        wrByte <= outByte;
        wrMark <= outMark;
        wrByteValid <= 1'b1;
        dmaHave_q <= 1'b0;
        if (state_q == ST_MARK) begin
          crc_q <= crcStep(`DTC_CRC_INIT, outByte);
        end else if (state_q == ST_ID || state_q == ST_DATA) begin
          crc_q <= crcStep(crc_q, outByte);
          if (needDma) begin
            range_q <= range_q - 16'h0001;
          end
        end
        if (count_q > 8'h01) begin
          count_q <= count_q - 8'h01;
        end else begin
          case (state_q)
            ST_GAP: begin
              state_q <= ST_SYNC;
              count_q <= `DTC_SYNC;
              case (field_q)
                FLD_GAP1: field_q <= idxMarkEn_q ? FLD_IDXM : FLD_IDM;
                FLD_GAP2: field_q <= FLD_IDM;
                FLD_GAP3: field_q <= FLD_DATM;
                default: field_q <= FLD_IDM;
              endcase
              if (field_q == FLD_GAP1 && !idxMarkEn_q) begin
                state_q <= ST_GAP;
                field_q <= FLD_GAP2;
                count_q <= `DTC_GAP2;
              end
              if (field_q == FLD_GAP4) begin
                secCount_q <= secCount_q + 8'h01;
                if (!isFormat || secCount_q + 8'h01 == `DTC_SECTORS || range_q == 16'h0000) begin
                  state_q <= ST_DONE;
                end
              end
            end
            ST_SYNC: begin
              state_q <= ST_MARK;
              count_q <= 8'h01;
            end
            ST_MARK: begin
              if (field_q == FLD_IDXM) begin
                state_q <= ST_GAP;
                field_q <= FLD_GAP2;
                count_q <= `DTC_GAP2;
              end else if (field_q == FLD_IDM) begin
                state_q <= ST_ID;
                count_q <= `DTC_ID_LEN;
              end else begin
                state_q <= ST_DATA;
                count_q <= `DTC_DATA_LEN;
              end
            end
            ST_ID: begin
              state_q <= ST_CRC;
              count_q <= 8'h00;
            end
            ST_DATA: begin
              state_q <= ST_CRC;
              count_q <= 8'h00;
            end
            ST_CRC: begin
              if (count_q == 8'h00) begin
                count_q <= 8'h01;
              end else begin
                state_q <= ST_GAP;
                field_q <= (field_q == FLD_IDM) ? FLD_GAP3 : FLD_GAP4;
                count_q <= (field_q == FLD_IDM) ? `DTC_GAP3 : `DTC_GAP4;
                if (field_q == FLD_DATM && !isFormat) begin
                  cfgB_q[7:0] <= cfgB_q[7:0] + 8'h01;
                end
              end
            end
            default: state_q <= ST_IDLE;
          endcase
        end
      end
      if (!busy_q) begin
        state_q <= (regWr && regAddr == `DTC_REG_TASK && regWrData[2:0] != 3'h0) ? ST_WAIT : ST_IDLE;
      end
      // Track number in range keeps the task meaningful.
      if (busy_q && state_q == ST_WAIT && cfgA_q[7:0] > `DTC_LAST_TRACK) begin
        readErr_q <= 1'b1;
        state_q <= ST_DONE;
      end
    end
  end
endmodule

// ==== verif/dtc_track_controller_props.sv ====
// Port checker for the diskette track controller.
`timescale 1ns/1ns
module dtc_track_controller_props (
  input wire clk,
  input wire rst,
  input wire [3:0] regAddr,
  input wire [15:0] regWrData,
  input wire regWr,
  input wire regRd,
  input wire regNak,
  input wire dmaReq,
  input wire [15:0] dmaAddr,
  input wire dmaAck,
  input wire [7:0] dmaWrData,
  input wire dmaWrite,
  input wire irq,
  input wire wrByteValid,
  input wire wrGate
);
  reg taskSeen_q;
  always @(posedge clk)
    taskSeen_q <= !rst && (taskSeen_q || (regWr && regAddr == 4'h4 && regWrData != 16'h0000));
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_nakCause; regNak |-> $past(regWr || regRd); endproperty
  a_nakCause: assert property (p_nakCause) else $error("refusal without a strobe");
  property p_ctrlTaken; regWr && regAddr == 4'h5 |=> !regNak; endproperty
  a_ctrlTaken: assert property (p_ctrlTaken) else $error("control word refused");
  property p_startAfterTask; $rose(dmaReq) || $rose(wrGate) |-> taskSeen_q; endproperty
  a_startAfterTask: assert property (p_startAfterTask) else $error("start before task");
  property p_reqHeld; dmaReq && !dmaAck |=> dmaReq && $stable(dmaAddr); endproperty
  a_reqHeld: assert property (p_reqHeld) else $error("request dropped early");
  property p_wrHeld; dmaReq && dmaWrite && !dmaAck |=> dmaWrite && $stable(dmaWrData); endproperty
  a_wrHeld: assert property (p_wrHeld) else $error("write data moved");
  property p_irqPulse; irq |=> !irq; endproperty
  a_irqPulse: assert property (p_irqPulse) else $error("interrupt too long");
  property p_gateValid; wrByteValid |-> wrGate; endproperty
  a_gateValid: assert property (p_gateValid) else $error("byte without gate");
  property p_validSingle; wrByteValid |=> !wrByteValid; endproperty
  a_validSingle: assert property (p_validSingle) else $error("byte strobe too long");
  property p_resetQuiet; $fell(rst) |-> !irq && !wrGate && !dmaReq && !regNak; endproperty
  a_resetQuiet: assert property (p_resetQuiet) else $error("active after reset");
  c_irq: cover property (irq);
  c_nak: cover property (regNak);
  c_dmaWr: cover property (dmaReq && dmaAck && dmaWrite);
endmodule
bind dtc_track_controller dtc_track_controller_props dtc_track_controller_props_i (
  .clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
  .regRd(regRd), .regNak(regNak), .dmaReq(dmaReq), .dmaAddr(dmaAddr), .dmaAck(dmaAck),
  .dmaWrData(dmaWrData), .dmaWrite(dmaWrite), .irq(irq), .wrByteValid(wrByteValid),
  .wrGate(wrGate));

// ==== verif/dtc_host_mem.sv ====
// Host memory model answering the controller's DMA requests.
`timescale 1ns/1ns
module dtc_host_mem (
  input wire clk,
  input wire rst,
  input wire slow,
  input wire dmaReq,
  input wire [15:0] dmaAddr,
  input wire dmaWrite,
  input wire [7:0] dmaWrData,
  output reg dmaAck,
  output reg [7:0] dmaRdData
);
  reg [7:0] mem [0:255];
  reg [2:0] waitCnt_q;
  // Read data is valid only with the acknowledge; otherwise it toggles.
  always @(posedge clk) begin
    dmaAck <= 1'b0;
    dmaRdData <= ~dmaRdData;
    if (rst) begin
      waitCnt_q <= 3'h0;
      dmaRdData <= 8'h00;
    end else if (dmaReq && !dmaAck) begin
      if (waitCnt_q >= (slow ? 3'h4 : 3'h0)) begin
        dmaAck <= 1'b1;
        waitCnt_q <= 3'h0;
        if (dmaWrite) begin
          mem[dmaAddr[7:0]] <= dmaWrData;
        end else begin
          dmaRdData <= mem[dmaAddr[7:0]];
        end
      end else begin
        waitCnt_q <= waitCnt_q + 3'h1;
      end
    end
  end
endmodule

// ==== verif/dtc_track_controller_tb_top.sv ====
// Self-checking bench for the diskette track controller.
`timescale 1ns/1ns
`include "dtc_defines.vh"
module dtc_track_controller_tb_top;
  reg clk = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0, indexPulse = 1'b0;
  reg rdByteValid = 1'b0, rdMarkFlag = 1'b0, otherXfer = 1'b0, byteTick = 1'b0, slow = 1'b0, nk;
  reg [3:0] regAddr = 4'h0;
  reg [15:0] regWrData = 16'h0000;
  reg [7:0] rdByte = 8'h00;
  reg [2:0] tickCnt = 3'h0;
  wire [15:0] regRdData, dmaAddr;
  wire [7:0] dmaRdData, dmaWrData, wrByte;
  wire regNak, dmaReq, dmaAck, dmaWrite, irq, wrMark, wrByteValid, wrGate;
  reg [8:0] got [0:2047];
  reg [8:0] exp [0:511];
  reg [35:0] rows [0:6];
  reg [15:0] v, crc, c;
  integer fails = 0, n_tests = 0, nGot = 0, irqCnt = 0, ne, base, irq0, i, j, im;
  always #50 clk = ~clk;
  dtc_track_controller dtc_track_controller_i (.clk(clk), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .regNak(regNak), .dmaReq(dmaReq), .dmaAddr(dmaAddr), .dmaAck(dmaAck),
    .dmaRdData(dmaRdData), .dmaWrData(dmaWrData), .dmaWrite(dmaWrite), .irq(irq),
    .indexPulse(indexPulse), .rdByte(rdByte), .rdByteValid(rdByteValid),
    .rdMarkFlag(rdMarkFlag), .otherXfer(otherXfer), .wrByte(wrByte), .wrMark(wrMark),
    .wrByteValid(wrByteValid), .wrGate(wrGate), .byteTick(byteTick));
  dtc_host_mem dtc_host_mem_i (.clk(clk), .rst(rst), .slow(slow), .dmaReq(dmaReq),
    .dmaAddr(dmaAddr), .dmaWrite(dmaWrite), .dmaWrData(dmaWrData), .dmaAck(dmaAck),
    .dmaRdData(dmaRdData));
  always @(posedge clk) begin
    tickCnt <= tickCnt + 3'h1;
    byteTick <= (tickCnt[2:1] == 2'b11);
    if (wrByteValid && nGot < 2048) begin
      got[nGot] <= {wrMark, wrByte};
      nGot <= nGot + 1;
    end
    if (irq) begin
      irqCnt <= irqCnt + 1;
    end
  end
  // ****************************************
  // Helper tasks.
  // ****************************************
  task summarize;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
        $display("Test passed");
      end else begin
        $display("Test failed");
      end
      $finish;
    end
  endtask
  task chk(input [15:0] seen, input [15:0] want);
    begin
      n_tests = n_tests + 1;
      if (seen !== want) begin
        fails = fails + 1;
        $display("BAD %0t: saw %h want %h", $time, seen, want);
      end
    end
  endtask
  function [15:0] crcNext(input [15:0] cin, input [7:0] b);
    integer k;
    begin
      crcNext = cin;
      for (k = 7; k >= 0; k = k - 1) begin
        crcNext = {crcNext[14:0], 1'b0} ^ ((crcNext[15] ^ b[k]) ? `DTC_CRC_POLY : 16'h0000);
      end
    end
  endfunction
  task acc(input w, input [3:0] a, input [15:0] d);
    begin
      @(posedge clk);
      regAddr <= a;
      regWrData <= d;
      regWr <= w;
      regRd <= !w;
      @(posedge clk);
      regWr <= 1'b0;
      regRd <= 1'b0;
      #1 v = regRdData;
      nk = regNak;
    end
  endtask
  task setup(input [15:0] ad, input [15:0] rg, input [15:0] cb, input [15:0] ct,
    input [2:0] tk);
    begin
      acc(1'b1, 4'h0, ad);
      acc(1'b1, 4'h1, rg);
      acc(1'b1, 4'h2, 16'h0012);
      acc(1'b1, 4'h3, cb);
      acc(1'b1, 4'h5, ct);
      acc(1'b1, 4'h4, {13'h0000, tk});
      chk(nk, 1'b0);
    end
  endtask
  task waitIrq(input integer n);
    integer k;
    begin
      for (k = 0; k < 40000 && irqCnt < n; k = k + 1) begin
        @(posedge clk);
      end
      if (irqCnt < n) begin
        fails = fails + 1;
        $display("BAD %0t: no interrupt", $time);
        summarize;
      end
    end
  endtask
  task put(input m, input [7:0] b);
    begin
      exp[ne] = {m, b};
      ne = ne + 1;
      crc = crcNext(crc, b);
    end
  endtask
  task putN(input integer n);
    repeat (n) put(1'b0, 8'h00);
  endtask
  task pulseIdx;
    begin
      @(posedge clk);
      indexPulse <= 1'b1;
      repeat (4) @(posedge clk);
      indexPulse <= 1'b0;
    end
  endtask
  task putCrc;
    begin
      c = crc;
      put(1'b0, c[15:8]);
      put(1'b0, c[7:0]);
    end
  endtask
  task putSector(input [7:0] sec, input last);
    begin
      putN(6);
      crc = `DTC_CRC_INIT;
      put(1'b1, `DTC_ID_MARK);
      put(1'b0, 8'h12);
      put(1'b0, 8'h00);
      put(1'b0, sec);
      put(1'b0, 8'h00);
      putCrc;
      putN(17);
      crc = `DTC_CRC_INIT;
      put(1'b1, `DTC_DATA_MARK);
      putN(128);
      putCrc;
      if (!last) putN(27);
    end
  endtask
  task send(input m, input [7:0] b);
    begin
      @(posedge clk);
      rdByte <= b;
      rdMarkFlag <= m;
      rdByteValid <= 1'b1;
      crc = crcNext(crc, b);
      @(posedge clk);
      rdByteValid <= 1'b0;
      rdByte <= ~b;
      repeat (6) @(posedge clk);
    end
  endtask
  task sendField(input [7:0] mk, input [7:0] sec, input bad);
    integer k;
    begin
      repeat (6) send(1'b0, 8'h00);
      crc = `DTC_CRC_INIT;
      send(1'b1, mk);
      if (mk == `DTC_ID_MARK) begin
        send(1'b0, 8'h12);
        send(1'b0, 8'h00);
        send(1'b0, sec);
        send(1'b0, 8'h00);
      end else begin
        for (k = 0; k < 128; k = k + 1) send(1'b0, k[7:0] ^ sec);
      end
      c = crc ^ {15'h0000, bad};
      send(1'b0, c[15:8]);
      send(1'b0, c[7:0]);
    end
  endtask
  // ****************************************
  // Main sequence.
  // ****************************************
  initial begin
    rows[0] = {4'h0, 16'h0040, 16'h0040};
    rows[1] = {4'h1, 16'h0008, 16'h0008};
    rows[2] = {4'h2, 16'h0012, 16'h0012};
    rows[3] = {4'h3, 16'h0007, 16'h0007};
    rows[4] = {4'h5, 16'h0003, 16'h0003};
    rows[5] = {4'h7, 16'h0001, 16'h0001};
    rows[6] = {4'h7, 16'h0000, 16'h0000};
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1 chk({irq, wrGate, dmaReq, regNak, wrByteValid}, 5'h00);
    for (i = 0; i < 7; i = i + 1) begin
      acc(1'b1, rows[i][35:32], rows[i][31:16]);
      chk(nk, 1'b0);
      acc(1'b0, rows[i][35:32], 16'h0000);
      chk(v, rows[i][15:0]);
    end
    acc(1'b0, 4'hf, 16'h0000);
    chk(nk, 1'b0);
    $display("register rows done");
    for (im = 1; im >= 0; im = im - 1) begin
      for (i = 0; i < 8; i = i + 1) dtc_host_mem_i.mem[8'h40 + i] = 8'h00;
      dtc_host_mem_i.mem[8'h40] = 8'h12;
      dtc_host_mem_i.mem[8'h42] = 8'h09;
      dtc_host_mem_i.mem[8'h44] = 8'h12;
      dtc_host_mem_i.mem[8'h46] = 8'h03;
      slow <= (im == 0);
      otherXfer <= (im == 1);
      base = nGot;
      irq0 = irqCnt;
      setup(16'h0040, 16'h0008, 16'h0001, {14'h0000, im[0], 1'b1}, `DTC_TASK_FORMAT);
      repeat (30) @(posedge clk);
      if (im == 1) chk({dmaReq, wrGate}, 2'b00);
      acc(1'b0, 4'h6, 16'h0000);
      chk(nk, 1'b1);
      acc(1'b1, 4'h2, 16'h0099);
      chk(nk, 1'b1);
      acc(1'b1, 4'h5, {14'h0000, im[0], 1'b1});
      chk(nk, 1'b0);
      otherXfer <= 1'b0;
      pulseIdx;
      ne = 0;
      putN(im ? 40 : 47);
      if (im) begin
        putN(6);
        put(1'b1, `DTC_INDEX_MARK);
      end
      putN(26);
      putSector(8'h09, 1'b0);
      putSector(8'h03, 1'b1);
      waitIrq(irq0 + 1);
      chk(nGot - base >= ne, 1'b1);
      for (i = 0; i < ne; i = i + 1) chk(got[base + i], exp[i]);
      acc(1'b0, 4'h6, 16'h0000);
      chk(v[0], 1'b0);
      $display("format test %0d done", im);
    end
    irq0 = irqCnt;
    setup(16'h0000, 16'h0100, 16'h0005, 16'h0005, `DTC_TASK_READ);
    pulseIdx;
    sendField(`DTC_ID_MARK, 8'h06, 1'b0);
    sendField(`DTC_DATA_MARK, 8'h06, 1'b0);
    sendField(`DTC_ID_MARK, 8'h05, 1'b0);
    sendField(`DTC_DEL_MARK, 8'h0a, 1'b0);
    sendField(`DTC_ID_MARK, 8'h05, 1'b0);
    sendField(`DTC_DATA_MARK, 8'h05, 1'b0);
    sendField(`DTC_ID_MARK, 8'h06, 1'b0);
    sendField(`DTC_DATA_MARK, 8'h06, 1'b0);
    waitIrq(irq0 + 1);
    acc(1'b0, 4'h3, 16'h0000);
    chk(v[7:0], 8'h07);
    for (i = 0; i < 256; i++) chk(dtc_host_mem_i.mem[i], i[7:0] ^ (i[7] ? 8'h86 : 8'h05));
    $display("read test done");
    irq0 = irqCnt;
    setup(16'h0080, 16'h0080, 16'h0006, 16'h0001, `DTC_TASK_READ);
    pulseIdx;
    sendField(`DTC_ID_MARK, 8'h06, 1'b0);
    sendField(`DTC_DATA_MARK, 8'h06, 1'b1);
    waitIrq(irq0 + 1);
    acc(1'b0, 4'h3, 16'h0000);
    chk(v[7:0], 8'h06);
    acc(1'b0, 4'h6, 16'h0000);
    chk(v[1], 1'b1);
    $display("read error test done");
    for (i = 0; i < 128; i = i + 1) dtc_host_mem_i.mem[8'h80 + i] = i[7:0] ^ 8'h06;
    irq0 = irqCnt;
    base = nGot;
    setup(16'h0080, 16'h0080, 16'h0007, 16'h0001, `DTC_TASK_WRDEL);
    pulseIdx;
    sendField(`DTC_ID_MARK, 8'h07, 1'b0);
    waitIrq(irq0 + 1);
    j = base;
    while (j < nGot && got[j] !== {1'b1, `DTC_DEL_MARK}) j = j + 1;
    chk(got[j], {1'b1, `DTC_DEL_MARK});
    crc = crcNext(`DTC_CRC_INIT, `DTC_DEL_MARK);
    for (i = 0; i < 128; i = i + 1) begin
      chk(got[j + 1 + i], {1'b0, i[7:0] ^ 8'h06});
      crc = crcNext(crc, i[7:0] ^ 8'h06);
    end
    chk({got[j + 129][7:0], got[j + 130][7:0]}, crc);
    acc(1'b0, 4'h3, 16'h0000);
    chk(v[7:0], 8'h08);
    $display("deleted write test done");
    setup(16'h0040, 16'h0008, 16'h0001, 16'h0003, `DTC_TASK_FORMAT);
    pulseIdx;
    repeat (200) @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    irq0 = irqCnt;
    repeat (100) @(posedge clk);
    chk(irqCnt, irq0);
    acc(1'b0, 4'h6, 16'h0000);
    chk(v[0], 1'b0);
    $display("reset abort test done");
    summarize;
  end
endmodule
